//--- verilog/pwsv_power_saver.sv
`timescale 1ns/10ps
// Overview of operation
// - Control write with bit 0 set stops core clock; zero has no effect.
// - Idle core clock restarts on an enabled interrupt request or hardware reset.
// - Core clock runs after reset, never idle out of reset.
// - Set register ones enable clocks, clear register ones disable; zeros change nothing.
// - A disabled peripheral clock stops at once, no waiting for activity.
// - Gating never resets peripheral state; re-enabled peripheral resumes where it stopped.
// - Status register shows one per enabled clock; reads 0x17c after reset.
// - Reset enables every gated peripheral clock without software help.
// - Clock bits: serial 2,3; timers 4 to 6; parallel io 8.
module pwsv_power_saver #(
    parameter int unsigned APB_ADDR_W = 32
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          pclk_en,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [APB_ADDR_W-1:0]         paddr,
    input  wire logic [pwsv_pkg::DATA_W-1:0]   pwdata,
    output logic      [pwsv_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          irq_wake,
    output logic                               core_clock,
    output logic                               core_idle,
    output logic                               serial_port_a_clock,
    output logic                               serial_port_b_clock,
    output logic                               timer_a_clock,
    output logic                               timer_b_clock,
    output logic                               timer_c_clock,
    output logic                               parallel_io_clock
);

    // Offset match, shared by write strobes, read mux and checks
    function automatic logic reg_hit(
        input logic [pwsv_pkg::DEC_W-1:0] offset,
        input logic [pwsv_pkg::DEC_W-1:0] target
    );
        return offset == target;
    endfunction

    // True for the four mapped, word aligned offsets
    function automatic logic reg_known(input logic [pwsv_pkg::DEC_W-1:0] offset);
        return reg_hit(offset, pwsv_pkg::OFF_POWER_CONTROL)
            || reg_hit(offset, pwsv_pkg::OFF_PERIPH_CLOCK_SET)
            || reg_hit(offset, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR)
            || reg_hit(offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE);
    endfunction

    pwsv_pkg::pwsv_apb_req_t          req;
    pwsv_pkg::pwsv_apb_rsp_t          rsp;
    pwsv_pkg::pwsv_apb_rsp_t          next_rsp;
    pwsv_pkg::pwsv_apb_rsp_t          read_value;
    logic                             armed;
    logic                             next_armed;
    logic                             acc_wr;
    logic                             wr_ctrl;
    logic                             wr_set;
    logic                             wr_clr;
    logic [pwsv_pkg::PERIPH_W-1:0]    wd_low;
    pwsv_pkg::pwsv_core_state_t       core_state;
    pwsv_pkg::pwsv_core_state_t       next_core_state;
    logic [pwsv_pkg::PERIPH_W-1:0]    periph_en;
    logic [pwsv_pkg::PERIPH_W-1:0]    next_periph_en;
    logic [pwsv_pkg::NUM_PERIPH-1:0]  periph_clk;
    logic                             rst_seen;
    logic                             next_rst_seen;

    // Bundle the bus request; upper address bits are decoded outside
    assign req = '{offset: paddr[pwsv_pkg::DEC_W-1:0], write: pwrite, wdata: pwdata};
    assign wd_low = req.wdata[pwsv_pkg::PERIPH_W-1:0];

    // Read mux: write-only registers read zero, unmapped offsets flag an error
    always_comb begin
        read_value = '{data: pwsv_pkg::RDATA_ZERO, err: 1'b0};
        if (reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE)) begin
            read_value.data = {{(pwsv_pkg::DATA_W-pwsv_pkg::PERIPH_W){1'b0}}, periph_en};
        end else if (!reg_known(req.offset)) begin
            read_value.err = 1'b1;
        end
    end

    // Answer is captured while selected; the access phase completes once armed
    always_comb begin
        next_armed = armed;
        next_rsp   = rsp;
        if (pclk_en) begin
            next_armed = psel && !pready;
            if (psel) begin
                next_rsp = read_value;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
            rsp   <= '{data: pwsv_pkg::RDATA_ZERO, err: 1'b0};
        end else begin
            armed <= next_armed;
            rsp   <= next_rsp;
        end
    end

    // Handshake: access phase ends once the answer is registered and the block runs
    assign pready  = psel && penable && pclk_en && armed;
    assign prdata  = rsp.data;
    assign pslverr = pready && rsp.err;

    // Write strobes fire only at the completing edge; status writes are dropped
    assign acc_wr  = pready && req.write;
    assign wr_ctrl = acc_wr && reg_hit(req.offset, pwsv_pkg::OFF_POWER_CONTROL);
    assign wr_set  = acc_wr && reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_SET);
    assign wr_clr  = acc_wr && reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR);

    // Core clock state: idle on request, back to run on an enabled interrupt
    always_comb begin
        next_core_state = core_state;
        if (pclk_en) begin
            case (core_state)
                pwsv_pkg::CORE_RUN: begin
                    if (wr_ctrl && req.wdata[pwsv_pkg::CPU_BIT]) begin
                        next_core_state = pwsv_pkg::CORE_IDLE;
                    end
                end
                pwsv_pkg::CORE_IDLE: begin
                    if (irq_wake) begin
                        next_core_state = pwsv_pkg::CORE_RUN;
                    end
                end
                default: begin
                    next_core_state = pwsv_pkg::CORE_RUN;
                end
            endcase
        end
    end

    // Reset leaves the core clock running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_state <= pwsv_pkg::CORE_RUN;
        end else begin
            core_state <= next_core_state;
        end
    end

    assign core_idle = (core_state == pwsv_pkg::CORE_IDLE);

    // Peripheral enables: set and clear by ones, reserved bits masked off
    always_comb begin
        next_periph_en = periph_en;
        if (wr_set) begin
            next_periph_en = periph_en | (wd_low & pwsv_pkg::PERIPH_MAP);
        end else if (wr_clr) begin
            next_periph_en = periph_en & ~(wd_low & pwsv_pkg::PERIPH_MAP);
        end
    end

    // Reset enables every peripheral clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_en <= pwsv_pkg::PERIPH_RST;
        end else begin
            periph_en <= next_periph_en;
        end
    end

    // Core clock gate; a stopped core needs an interrupt or reset to run again
    pwsv_clock_gate u_core_gate (
        .clk_in  (pclk),
        .enable  (core_state == pwsv_pkg::CORE_RUN),
        .clk_out (core_clock)
    );

    // One gate per peripheral, driven straight from its enable bit
    generate
        for (genvar g = 0; g < pwsv_pkg::NUM_PERIPH; g++) begin : gen_gate
            pwsv_clock_gate u_gate (
                .clk_in  (pclk),
                .enable  (periph_en[pwsv_pkg::PERIPH_BIT[g]]),
                .clk_out (periph_clk[g])
            );
        end
    endgenerate

    // Named peripheral clock outputs
    assign serial_port_a_clock = periph_clk[0];
    assign serial_port_b_clock = periph_clk[1];
    assign timer_a_clock       = periph_clk[2];
    assign timer_b_clock       = periph_clk[3];
    assign timer_c_clock       = periph_clk[4];
    assign parallel_io_clock   = periph_clk[5];

    // Marks the first edge after reset release, for the checks below
    always_comb begin
        next_rst_seen = rst_seen || pclk_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= next_rst_seen;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Core clock control
    chk_idle_entry: assert property (
        (pclk_en && wr_ctrl && req.wdata[pwsv_pkg::CPU_BIT] && core_state == pwsv_pkg::CORE_RUN)
        |=> (core_state == pwsv_pkg::CORE_IDLE) && core_idle
    ) else $error("core clock not stopped after control write");

    chk_ctrl_zero: assert property (
        (pclk_en && wr_ctrl && !req.wdata[pwsv_pkg::CPU_BIT] && core_state == pwsv_pkg::CORE_RUN)
        |=> core_state == pwsv_pkg::CORE_RUN
    ) else $error("control write of zero changed core clock");

    chk_wake_irq: assert property (
        (pclk_en && core_state == pwsv_pkg::CORE_IDLE && irq_wake)
        |=> core_state == pwsv_pkg::CORE_RUN
    ) else $error("core clock not restarted by interrupt");

    chk_idle_hold: assert property (
        (core_state == pwsv_pkg::CORE_IDLE && !(pclk_en && irq_wake))
        |=> core_state == pwsv_pkg::CORE_IDLE
    ) else $error("core left idle without interrupt");

    chk_reset_run: assert property (
        !rst_seen |-> (core_state == pwsv_pkg::CORE_RUN) && !core_idle
    ) else $error("core clock not running after reset");

    // Peripheral enable updates, register reads and bus answers
    chk_set_bits: assert property (
        (pclk_en && wr_set)
        |=> periph_en == ($past(periph_en) | ($past(wd_low) & pwsv_pkg::PERIPH_MAP))
    ) else $error("set write gave wrong enables");

    chk_clr_bits: assert property (
        (pclk_en && wr_clr)
        |=> periph_en == ($past(periph_en) & ~($past(wd_low) & pwsv_pkg::PERIPH_MAP))
    ) else $error("clear write gave wrong enables");

    chk_clr_stop: assert property (
        (pclk_en && wr_clr && ((wd_low & pwsv_pkg::PERIPH_MAP) != '0))
        |=> ((periph_en & $past(wd_low) & pwsv_pkg::PERIPH_MAP) == '0)
    ) else $error("cleared clock still enabled next cycle");

    chk_en_stable: assert property (
        !(wr_set || wr_clr) |=> $stable(periph_en)
    ) else $error("peripheral enable changed without a write");

    chk_status_read: assert property (
        (pclk_en && psel && !pwrite && reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE))
        |=> prdata == {{(pwsv_pkg::DATA_W-pwsv_pkg::PERIPH_W){1'b0}}, $past(periph_en)}
    ) else $error("status read does not match enables");

    chk_reset_en: assert property (
        !rst_seen |-> periph_en == pwsv_pkg::PERIPH_RST
    ) else $error("peripheral clocks not all enabled after reset");

    chk_map_bits: assert property (
        (periph_en & ~pwsv_pkg::PERIPH_MAP) == '0
    ) else $error("reserved enable bit set");

    chk_wo_zero: assert property (
        (pclk_en && psel && !pwrite && !reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE))
        |=> prdata == pwsv_pkg::RDATA_ZERO
    ) else $error("write-only or unmapped read not zero");

    chk_unmapped_err: assert property (
        pready |-> (pslverr == !reg_known(req.offset))
    ) else $error("error answer wrong for offset");

    chk_ready_bound: assert property (
        (psel && !penable && pclk_en) ##1 (psel && penable && pclk_en) |-> pready
    ) else $error("access phase not answered at once");

    // Clock enable, answer shape, core run hold and enable updates
    chk_stall_ready: assert property (
        !pclk_en |-> !pready && !pslverr
    ) else $error("answer given while clock enable low");

    chk_stall_freeze: assert property (
        !pclk_en |=> $stable(core_state) && $stable(armed) && $stable(rsp) && $stable(periph_en)
    ) else $error("state moved while clock enable low");

    chk_ready_once: assert property (
        pready |=> !pready
    ) else $error("ready held beyond one cycle");

    chk_err_flag: assert property (
        (pclk_en && psel && !reg_known(req.offset)) |=> rsp.err
    ) else $error("unmapped offset not flagged");

    chk_run_hold: assert property (
        (core_state == pwsv_pkg::CORE_RUN && !wr_ctrl)
        |=> core_state == pwsv_pkg::CORE_RUN
    ) else $error("core clock stopped without a control write");

    chk_status_wr_drop: assert property (
        (pready && pwrite && reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE))
        |=> $stable(periph_en)
    ) else $error("status write changed peripheral enables");

    chk_set_keep: assert property (
        (pclk_en && wr_set) |=> (periph_en & $past(periph_en)) == $past(periph_en)
    ) else $error("set write disabled a clock");

    chk_clr_keep: assert property (
        (pclk_en && wr_clr) |=> (periph_en & ~$past(periph_en)) == '0
    ) else $error("clear write enabled a clock");

    // Main scenarios
    cov_idle_wake: cover property (
        core_state == pwsv_pkg::CORE_IDLE ##1 core_state == pwsv_pkg::CORE_RUN
    );
    cov_clear_then_set: cover property (
        wr_clr ##[1:20] wr_set
    );
    cov_status_read: cover property (
        pready && !pwrite && reg_hit(req.offset, pwsv_pkg::OFF_PERIPH_CLOCK_STATE)
    );
    cov_unmapped: cover property (
        pslverr
    );
    cov_stall_access: cover property (
        (psel && penable && !pclk_en) ##[1:4] pready
    );

endmodule

//--- verilog/pwsv_pkg.sv
package pwsv_pkg;

    // Register window decode width and register offsets
    localparam int unsigned          DEC_W                  = 12;
    localparam logic [DEC_W-1:0]     OFF_POWER_CONTROL      = 12'h000;
    localparam logic [DEC_W-1:0]     OFF_PERIPH_CLOCK_SET   = 12'h004;
    localparam logic [DEC_W-1:0]     OFF_PERIPH_CLOCK_CLEAR = 12'h008;
    localparam logic [DEC_W-1:0]     OFF_PERIPH_CLOCK_STATE = 12'h00c;

    // Data path width
    localparam int unsigned          DATA_W                 = 32;
    localparam logic [DATA_W-1:0]    RDATA_ZERO             = 32'h0000_0000;

    // Control register field: core clock disable
    localparam int unsigned          CPU_BIT                = 0;

    // Peripheral clock field positions, equal to interrupt source numbers
    localparam int unsigned          PERIPH_W               = 9;
    localparam int unsigned          NUM_PERIPH             = 6;
    localparam int unsigned          BIT_SERIAL_A           = 2;
    localparam int unsigned          BIT_SERIAL_B           = 3;
    localparam int unsigned          BIT_TIMER_A            = 4;
    localparam int unsigned          BIT_TIMER_B            = 5;
    localparam int unsigned          BIT_TIMER_C            = 6;
    localparam int unsigned          BIT_PARALLEL_IO        = 8;
    localparam int unsigned          PERIPH_BIT [NUM_PERIPH] = '{BIT_SERIAL_A, BIT_SERIAL_B, BIT_TIMER_A,
                                                                 BIT_TIMER_B, BIT_TIMER_C, BIT_PARALLEL_IO};

    // Implemented peripheral clock bits and their reset value
    localparam logic [PERIPH_W-1:0]  PERIPH_MAP             = 9'h17c;
    localparam logic [PERIPH_W-1:0]  PERIPH_RST             = 9'h17c;

    // Core clock state
    typedef enum logic [0:0] {
        CORE_RUN  = 1'b0,
        CORE_IDLE = 1'b1
    } pwsv_core_state_t;

    // Bus request as seen by the register file
    typedef struct packed {
        logic [DEC_W-1:0]  offset;
        logic              write;
        logic [DATA_W-1:0] wdata;
    } pwsv_apb_req_t;

    // Registered bus answer
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              err;
    } pwsv_apb_rsp_t;

endpackage

//--- verilog/pwsv_clock_gate.sv
`timescale 1ns/10ps
module pwsv_clock_gate (
    input  wire logic clk_in,
    input  wire logic enable,
    output wire logic clk_out
);

    logic enable_lat;

    // Enable passes only while the clock is low, so the output never glitches
    always_latch begin
        if (!clk_in) begin
            enable_lat <= enable;
        end
    end

    // Gating touches only the clock, never the state behind it
    assign clk_out = clk_in & enable_lat;

endmodule

//--- verification/pwsv_far_side.sv
`timescale 1ns/10ps
// Stand-in for the core and peripheral domains: one activity counter per gated clock
module pwsv_far_side (
    input  wire logic        presetn,
    input  wire logic        core_clock,
    input  wire logic [5:0]  periph_clocks,
    output logic      [15:0] core_ticks,
    output logic      [15:0] periph_ticks [6]
);
    // Core progress only moves while its clock runs
    always_ff @(posedge core_clock or negedge presetn) begin
        if (!presetn) begin
            core_ticks <= 16'h0000;
        end else begin
            core_ticks <= core_ticks + 16'h0001;
        end
    end

    // Peripheral state survives gating; only a hardware reset clears it
    for (genvar g = 0; g < 6; g++) begin : g_periph
        always_ff @(posedge periph_clocks[g] or negedge presetn) begin
            if (!presetn) begin
                periph_ticks[g] <= 16'h0000;
            end else begin
                periph_ticks[g] <= periph_ticks[g] + 16'h0001;
            end
        end
    end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        pclk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        irq_wake;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic [31:0] expv;
    logic [31:0] mask;
    logic        pready;
    logic        pslverr;
    logic        rde;
    logic        core_clock;
    logic        core_idle;
    logic [5:0]  pclks;
    logic [15:0] core_ticks;
    logic [15:0] ticks [6];
    logic [15:0] frozen [6];
    logic [15:0] t0;
    int          fail_count;
    int          check_count;
    int          i;

    pwsv_power_saver #(.APB_ADDR_W(32)) dut (
        .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_wake(irq_wake), .core_clock(core_clock), .core_idle(core_idle),
        .serial_port_a_clock(pclks[0]), .serial_port_b_clock(pclks[1]), .timer_a_clock(pclks[2]),
        .timer_b_clock(pclks[3]), .timer_c_clock(pclks[4]), .parallel_io_clock(pclks[5])
    );

    pwsv_far_side far (
        .presetn(presetn), .core_clock(core_clock), .periph_clocks(pclks),
        .core_ticks(core_ticks), .periph_ticks(ticks)
    );

    // System clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Closing report
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {20'h00000, off};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        rde = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        #1;
    endtask

    // Wait a few cycles and sample once settled
    task automatic idle_cycles(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    initial begin
        presetn = 1'b0; pclk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; irq_wake = 1'b0; fail_count = 0; check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        idle_cycles(1);
        check("core_idle_reset", 32'h0, core_idle);
        apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        check("state_reset", 32'h17c, rdv);
        // Write-only registers read zero, unmapped offset errors
        for (i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("wo_read", 32'h0, rdv);
            check("wo_err", 32'h0, {31'h0, rde});
        end
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, rde});
        check("unmapped_read", 32'h0, rdv);
        // Status writes, zero writes and reserved bits change nothing
        apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR, 32'h0);
        apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR, ~32'h17c);
        apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        check("state_kept", 32'h17c, rdv);
        // Disable each peripheral clock in turn; its domain stays quiet afterwards
        expv = 32'h17c;
        for (i = 0; i < 6; i++) begin
            mask = 32'h1 << pwsv_pkg::PERIPH_BIT[i];
            expv = expv & ~mask;
            apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR, mask);
            t0 = ticks[i];
            apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
            check("state_clear", expv, rdv);
            idle_cycles(4);
            check("gated_stopped", {16'h0, t0}, {16'h0, ticks[i]});
            frozen[i] = ticks[i];
        end
        apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_SET, 32'hffff_ffff);
        apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        check("state_set", 32'h17c, rdv);
        idle_cycles(4);
        for (i = 0; i < 6; i++) begin
            check("resumed", {16'h0, frozen[i] + 16'h0007}, {16'h0, ticks[i]});
        end
        // Core clock: zero write no effect, one stops, wake request restarts
        apb(1'b1, pwsv_pkg::OFF_POWER_CONTROL, 32'h0);
        idle_cycles(1);
        check("ctrl_zero", 32'h0, core_idle);
        apb(1'b1, pwsv_pkg::OFF_POWER_CONTROL, 32'h1);
        idle_cycles(1);
        check("ctrl_one", 32'h1, core_idle);
        t0 = core_ticks;
        idle_cycles(4);
        check("core_stopped", {16'h0, t0}, {16'h0, core_ticks});
        @(posedge pclk);
        irq_wake <= 1'b1;
        idle_cycles(1);
        check("wake_irq", 32'h0, core_idle);
        @(posedge pclk);
        irq_wake <= 1'b0;
        #1;
        t0 = core_ticks;
        idle_cycles(3);
        check("core_runs", {16'h0, t0 + 16'h0003}, {16'h0, core_ticks});
        // Clock enable low holds the access phase open; the write lands once it returns
        @(posedge pclk);
        pclk_en <= 1'b0;
        fork
            apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR, 32'h4);
            begin
                repeat (4) @(posedge pclk);
                check("stall_ready", 32'h0, {31'h0, pready});
                pclk_en <= 1'b1;
            end
        join
        apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        check("stall_clear", 32'h178, rdv);
        // Idle again with two peripherals off, then a hardware reset mid-run
        apb(1'b1, pwsv_pkg::OFF_PERIPH_CLOCK_CLEAR, 32'h100);
        apb(1'b1, pwsv_pkg::OFF_POWER_CONTROL, 32'h1);
        idle_cycles(1);
        check("idle_again", 32'h1, core_idle);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        check("reset_wake", 32'h0, core_idle);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pwsv_pkg::OFF_PERIPH_CLOCK_STATE, 32'h0);
        check("state_rereset", 32'h17c, rdv);
        t0 = core_ticks;
        idle_cycles(2);
        check("core_rereset", {16'h0, t0 + 16'h0002}, {16'h0, core_ticks});
        wrap_up();
    end
endmodule
